// File: verilog/sram_port_device.sv
// Purpose: Device end of a four-word-burst separate-port DDR SRAM
// Assumes: Strobes mark K and K-bar rises; no strobe means clock stopped
// Notes: Read beat launched at a strobe shows on q the next cycle
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module sram_port_device #(
  parameter int DATA_W = `SP_DATA_W,
  parameter int MASK_W = `SP_MASK_W,
  parameter int ADDR_W = `SP_ADDR_W,
  parameter int READ_LAT = `SP_READ_LAT
)(
  input wire logic clk,
  input wire logic rst,
  sram_port_if.device link,
  output logic read_active,
  output logic write_active
);

  localparam int LANE_W = `SP_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  ////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [DATA_W-1:0] mem [0:DEPTH-1];

  sram_port_pkg::last_op_e last_reg;
  sram_port_pkg::last_op_e last_next;

  logic [READ_LAT-1:0] rpipe_v_reg;
  logic [READ_LAT-1:0] rpipe_v_next;
  logic [ADDR_W-1:0] rpipe_a_reg [READ_LAT];
  logic [ADDR_W-1:0] rpipe_a_next [READ_LAT];

  logic rd_act_reg;
  logic rd_act_next;
  logic [1:0] rd_beat_reg;
  logic [1:0] rd_beat_next;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic [ADDR_W-1:0] rd_addr_next;
  logic [DATA_W-1:0] q_reg;
  logic [DATA_W-1:0] q_next;
  logic q_oe_reg;
  logic q_oe_next;

  logic wr_pend_reg;
  logic wr_pend_next;
  logic [ADDR_W-1:0] wr_pend_addr_reg;
  logic [ADDR_W-1:0] wr_pend_addr_next;
  logic wr_act_reg;
  logic wr_act_next;
  logic [1:0] wr_beat_reg;
  logic [1:0] wr_beat_next;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] wr_addr_next;

  // Combinational decisions for the current strobe
  logic rd_ok;
  logic wr_ok;
  logic rd_go;
  logic wr_go;
  logic rd_fire;
  logic [1:0] rd_fire_beat;
  logic [ADDR_W-1:0] rd_fire_addr;
  logic wr_fire;
  logic [1:0] wr_fire_beat;
  logic [ADDR_W-1:0] wr_fire_addr;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word address of one beat; wraps inside the array
  function automatic logic [ADDR_W-1:0] beat_addr(
    input logic [ADDR_W-1:0] base,
    input logic [1:0] beat
  );
    beat_addr = base + ADDR_W'(beat);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request acceptance on K rises

  // A select that just started an op is ignored, which also drops
  // a second request of the same type
  always_comb
  begin
    rd_ok = !link.read_select_n
      && last_reg != sram_port_pkg::OP_READ;
    wr_ok = !link.write_select_n
      && last_reg != sram_port_pkg::OP_WRITE;
    rd_go = link.k_rise && rd_ok;
    wr_go = link.k_rise && wr_ok && !rd_ok;
    last_next = last_reg;
    if (link.k_rise)
    begin
      if (rd_go)
        last_next = sram_port_pkg::OP_READ;
      else if (wr_go)
        last_next = sram_port_pkg::OP_WRITE;
      else
        last_next = sram_port_pkg::OP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: latency pipe then four beats

  // Pipe advances on K rises only, so a stopped clock holds it
  always_comb
  begin
    rpipe_v_next = rpipe_v_reg;
    rpipe_a_next = rpipe_a_reg;
    if (link.k_rise)
    begin
      for (int i = READ_LAT - 1; i > 0; i--)
      begin
        rpipe_v_next[i] = rpipe_v_reg[i-1];
        rpipe_a_next[i] = rpipe_a_reg[i-1];
      end
      rpipe_v_next[0] = rd_go;
      rpipe_a_next[0] = link.addr;
    end
  end

  // Beats 0,1 on the first K cycle, 2,3 on the next
  always_comb
  begin
    rd_fire = 1'b0;
    rd_fire_beat = rd_beat_reg;
    rd_fire_addr = rd_addr_reg;
    if (link.k_rise)
    begin
      if (rpipe_v_reg[READ_LAT-1])
      begin
        rd_fire = 1'b1;
        rd_fire_beat = 2'h0;
        rd_fire_addr = rpipe_a_reg[READ_LAT-1];
      end
      else if (rd_act_reg && rd_beat_reg == 2'h1)
      begin
        rd_fire = 1'b1;
        rd_fire_beat = 2'h2;
      end
    end
    else if (link.kn_rise && rd_act_reg && !rd_beat_reg[0])
    begin
      rd_fire = 1'b1;
      rd_fire_beat = rd_beat_reg + 2'h1;
    end
    rd_act_next = link.k_rise ? rd_fire : rd_act_reg;
    rd_beat_next = rd_fire ? rd_fire_beat : rd_beat_reg;
    rd_addr_next = rd_fire_addr;
    q_next = rd_fire ? mem[beat_addr(rd_fire_addr, rd_fire_beat)] : q_reg;
    // Bus released at the first K rise with nothing to send
    q_oe_next = rd_fire ? 1'b1 : (link.k_rise ? 1'b0 : q_oe_reg);
  end

  ////////////////////////////////////////////////////////////////////////
  // Write path: one K of wait then four beats

  // Pending slot lets a new write land while the last still bursts
  always_comb
  begin
    wr_fire = 1'b0;
    wr_fire_beat = wr_beat_reg;
    wr_fire_addr = wr_addr_reg;
    if (link.k_rise)
    begin
      if (wr_pend_reg)
      begin
        wr_fire = 1'b1;
        wr_fire_beat = 2'h0;
        wr_fire_addr = wr_pend_addr_reg;
      end
      else if (wr_act_reg && wr_beat_reg == 2'h1)
      begin
        wr_fire = 1'b1;
        wr_fire_beat = 2'h2;
      end
    end
    else if (link.kn_rise && wr_act_reg && !wr_beat_reg[0])
    begin
      wr_fire = 1'b1;
      wr_fire_beat = wr_beat_reg + 2'h1;
    end
    wr_act_next = link.k_rise ? wr_fire : wr_act_reg;
    wr_beat_next = wr_fire ? wr_fire_beat : wr_beat_reg;
    wr_addr_next = wr_fire_addr;
    wr_pend_next = link.k_rise ? wr_go : wr_pend_reg;
    wr_pend_addr_next = wr_go ? link.addr : wr_pend_addr_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Reset stands in for power-up: both ports deselected, bus off
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_reg <= sram_port_pkg::OP_NONE;
      rpipe_v_reg <= '0;
      rd_act_reg <= 1'b0;
      rd_beat_reg <= 2'h0;
      q_oe_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      wr_beat_reg <= 2'h0;
    end
    else
    begin
      last_reg <= last_next;
      rpipe_v_reg <= rpipe_v_next;
      rd_act_reg <= rd_act_next;
      rd_beat_reg <= rd_beat_next;
      q_oe_reg <= q_oe_next;
      wr_pend_reg <= wr_pend_next;
      wr_act_reg <= wr_act_next;
      wr_beat_reg <= wr_beat_next;
    end
    rpipe_a_reg <= rpipe_a_next;
    rd_addr_reg <= rd_addr_next;
    q_reg <= q_next;
    wr_pend_addr_reg <= wr_pend_addr_next;
    wr_addr_reg <= wr_addr_next;
  end

  // Lane writes; each mask bit is taken with its own beat
  always_ff @(posedge clk)
  begin
    if (wr_fire && !rst)
    begin
      for (int l = 0; l < MASK_W; l++)
      begin
        if (!link.lane_mask_n[l])
          mem[beat_addr(wr_fire_addr, wr_fire_beat)][l*LANE_W +: LANE_W]
            <= link.d[l*LANE_W +: LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign link.q = q_reg;
  assign link.q_oe = q_oe_reg;
  assign read_active = rd_act_reg;
  assign write_active = wr_act_reg;

endmodule

`default_nettype wire

// File: shared/sram_port_regs.svh
// Purpose: Constants shared by both ends of the burst SRAM port
// Assumes: One DDR beat per clk cycle, K and K-bar rises alternate
// Notes: Definitions only
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// Words per burst and lane width
`define SP_BURST_LEN 4
`define SP_LANE_W 9

// Default geometry, 18-bit word with two lanes
`define SP_DATA_W 18
`define SP_MASK_W 2
`define SP_ADDR_W 8

// Read latency in K rises
`define SP_READ_LAT 2

// One K period spans two clk cycles
`define SP_CLK_PER_K 2

`endif

// File: shared/sram_port_pkg.sv
// Purpose: Types shared by both ends of the burst SRAM port
// Assumes: Nothing
// Notes: Constants live in sram_port_regs.svh
package sram_port_pkg;

  // Kind of request started on the last K rise
  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} last_op_e;

endpackage

// File: shared/sram_port_if.sv
// Purpose: Link between memory controller and burst SRAM device
// Assumes: k_rise and kn_rise are one-cycle strobes from the controller
// Notes: q_oe high while the device drives the read bus
`timescale 1ns/1ps
`default_nettype none

interface sram_port_if #(
  parameter int DATA_W = 18,
  parameter int MASK_W = 2,
  parameter int ADDR_W = 8
);
  logic k_rise;
  logic kn_rise;
  logic [ADDR_W-1:0] addr;
  logic read_select_n;
  logic write_select_n;
  logic [DATA_W-1:0] d;
  logic [MASK_W-1:0] lane_mask_n;
  logic [DATA_W-1:0] q;
  logic q_oe;

  modport device (
    input k_rise, kn_rise, addr, read_select_n, write_select_n,
    input d, lane_mask_n,
    output q, q_oe
  );

  modport controller (
    output k_rise, kn_rise, addr, read_select_n, write_select_n,
    output d, lane_mask_n,
    input q, q_oe
  );
endinterface

`default_nettype wire

// File: verilog/sram_port_controller.sv
// Purpose: Controller end driving the burst SRAM device link
// Assumes: User holds a request and its data until acknowledged
// Notes: Link strobes come from a divide-by-two of clk while clk_run
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module sram_port_controller #(
  parameter int DATA_W = `SP_DATA_W,
  parameter int MASK_W = `SP_MASK_W,
  parameter int ADDR_W = `SP_ADDR_W
)(
  input wire logic clk,
  input wire logic rst,
  sram_port_if.controller link,
  input wire logic clk_run,
  input wire logic rd_req,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic rd_ack,
  input wire logic wr_req,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [`SP_BURST_LEN*DATA_W-1:0] wr_data,
  input wire logic [`SP_BURST_LEN*MASK_W-1:0] wr_mask_n,
  output logic wr_ack,
  output logic [`SP_BURST_LEN*DATA_W-1:0] rd_data,
  output logic rd_valid
);

  localparam int BDW = `SP_BURST_LEN * DATA_W;
  localparam int BMW = `SP_BURST_LEN * MASK_W;

  logic kphase_reg, kphase_next; // High: next strobe is a K rise
  logic k_reg, k_next, kn_reg, kn_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic rsel_n_reg, rsel_n_next, wsel_n_reg, wsel_n_next;
  sram_port_pkg::last_op_e last_reg, last_next;
  logic [BDW-1:0] pbuf_reg, pbuf_next, abuf_reg, abuf_next;
  logic [BMW-1:0] pmask_reg, pmask_next, amask_reg, amask_next;
  logic wpend_reg, wpend_next, wact_reg, wact_next;
  logic [1:0] wbeat_reg, wbeat_next;
  logic [DATA_W-1:0] d_reg, d_next;
  logic [MASK_W-1:0] mask_reg, mask_next;
  logic rd_ack_reg, rd_ack_next, wr_ack_reg, wr_ack_next;
  logic strobe_d_reg;
  logic [1:0] cap_reg, cap_next;
  logic [BDW-1:0] stage_reg, stage_next, rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic issue_rd, issue_wr, fire;
  logic [1:0] fire_beat;

  ////////////////////////////////////////////////////////////////////////
  // Request issue, one per K rise, never the same type twice running

  always_comb
  begin
    k_next = clk_run && kphase_reg;
    kn_next = clk_run && !kphase_reg;
    kphase_next = clk_run ? !kphase_reg : kphase_reg;
    issue_rd = k_next && rd_req
      && last_reg != sram_port_pkg::OP_READ;
    issue_wr = k_next && wr_req && !issue_rd
      && last_reg != sram_port_pkg::OP_WRITE;
    rsel_n_next = !issue_rd;
    wsel_n_next = !issue_wr;
    addr_next = issue_rd ? rd_addr : (issue_wr ? wr_addr : addr_reg);
    last_next = last_reg;
    if (k_next)
      last_next = issue_rd ? sram_port_pkg::OP_READ
        : (issue_wr ? sram_port_pkg::OP_WRITE : sram_port_pkg::OP_NONE);
    rd_ack_next = issue_rd;
    wr_ack_next = issue_wr;
  end

  ////////////////////////////////////////////////////////////////////////
  // Write beats, mirroring the device's t+1 and t+2 schedule

  // Two buffers so a new write may be taken while one still bursts
  always_comb
  begin
    fire = 1'b0;
    fire_beat = wbeat_reg;
    abuf_next = abuf_reg;
    amask_next = amask_reg;
    if (k_next && wpend_reg)
    begin
      fire = 1'b1;
      fire_beat = 2'h0;
      abuf_next = pbuf_reg;
      amask_next = pmask_reg;
    end
    else if (k_next && wact_reg && wbeat_reg == 2'h1)
    begin
      fire = 1'b1;
      fire_beat = 2'h2;
    end
    else if (kn_next && wact_reg && !wbeat_reg[0])
    begin
      fire = 1'b1;
      fire_beat = wbeat_reg + 2'h1;
    end
    wact_next = k_next ? fire : wact_reg;
    wbeat_next = fire ? fire_beat : wbeat_reg;
    wpend_next = k_next ? issue_wr : wpend_reg;
    pbuf_next = issue_wr ? wr_data : pbuf_reg;
    pmask_next = issue_wr ? wr_mask_n : pmask_reg;
    d_next = fire ? abuf_next[fire_beat*DATA_W +: DATA_W] : d_reg;
    // Idle beats carry all lanes masked
    mask_next = fire ? amask_next[fire_beat*MASK_W +: MASK_W]
      : {MASK_W{1'b1}};
  end

  ////////////////////////////////////////////////////////////////////////
  // Read capture: q is valid the cycle after each strobe

  always_comb
  begin
    cap_next = cap_reg;
    stage_next = stage_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = 1'b0;
    if (strobe_d_reg && link.q_oe)
    begin
      stage_next[cap_reg*DATA_W +: DATA_W] = link.q;
      cap_next = cap_reg + 2'h1;
      if (cap_reg == 2'h3)
      begin
        rd_data_next = stage_next;
        rd_valid_next = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      kphase_reg <= 1'b1;
      k_reg <= 1'b0;
      kn_reg <= 1'b0;
      addr_reg <= '0;
      rsel_n_reg <= 1'b1;
      wsel_n_reg <= 1'b1;
      last_reg <= sram_port_pkg::OP_NONE;
      wpend_reg <= 1'b0;
      wact_reg <= 1'b0;
      wbeat_reg <= 2'h0;
      d_reg <= '0;
      mask_reg <= {MASK_W{1'b1}};
      rd_ack_reg <= 1'b0;
      wr_ack_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      cap_reg <= 2'h0;
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      kphase_reg <= kphase_next;
      k_reg <= k_next;
      kn_reg <= kn_next;
      addr_reg <= addr_next;
      rsel_n_reg <= rsel_n_next;
      wsel_n_reg <= wsel_n_next;
      last_reg <= last_next;
      wpend_reg <= wpend_next;
      wact_reg <= wact_next;
      wbeat_reg <= wbeat_next;
      d_reg <= d_next;
      mask_reg <= mask_next;
      rd_ack_reg <= rd_ack_next;
      wr_ack_reg <= wr_ack_next;
      strobe_d_reg <= k_reg || kn_reg;
      cap_reg <= cap_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
    pbuf_reg <= pbuf_next;
    pmask_reg <= pmask_next;
    abuf_reg <= abuf_next;
    amask_reg <= amask_next;
    stage_reg <= stage_next;
  end

  assign link.k_rise = k_reg;
  assign link.kn_rise = kn_reg;
  assign link.addr = addr_reg;
  assign link.read_select_n = rsel_n_reg;
  assign link.write_select_n = wsel_n_reg;
  assign link.d = d_reg;
  assign link.lane_mask_n = mask_reg;
  assign rd_ack = rd_ack_reg;
  assign wr_ack = wr_ack_reg;
  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

endmodule

`default_nettype wire

// File: verif/sram_port_props.sv
// Purpose: Link protocol checks between the two burst SRAM port ends
// Assumes: Link clock runs free while a burst is in flight
// Notes: Take decode tracks the same-kind history of the device
`timescale 1ns/1ps
`default_nettype none

module sram_port_props #(
  parameter int DATA_W = 18,
  parameter int MASK_W = 2
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic k_rise,
  input wire logic kn_rise,
  input wire logic read_select_n,
  input wire logic write_select_n,
  input wire logic [MASK_W-1:0] lane_mask_n,
  input wire logic [DATA_W-1:0] q,
  input wire logic q_oe
);
  logic rd_last_reg;
  logic rd_last_next;
  logic wr_last_reg;
  logic wr_last_next;
  logic rd_take;
  logic wr_take;

  ////////////////////////////////////////////////////////////////
  // Accepted requests; read wins a tie unless a read went last
  assign rd_take = k_rise && !read_select_n && !rd_last_reg;
  assign wr_take = k_rise && !write_select_n && !wr_last_reg && !rd_take;

  // History moves only on K rises, so a stopped clock keeps it
  always_comb
  begin
    rd_last_next = k_rise ? rd_take : rd_last_reg;
    wr_last_next = k_rise ? wr_take : wr_last_reg;
  end

  always_ff @(posedge clk)
  begin
    rd_last_reg <= rst ? 1'b0 : rd_last_next;
    wr_last_reg <= rst ? 1'b0 : wr_last_next;
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Link checks
  idle_after_reset_a: assert property (
    $past(rst) |-> !q_oe && read_select_n && write_select_n)
    else $error("link not idle after reset");
  read_spacing_a: assert property (
    k_rise && rd_last_reg |-> read_select_n)
    else $error("read on consecutive K rises");
  write_spacing_a: assert property (
    k_rise && wr_last_reg |-> write_select_n)
    else $error("write on consecutive K rises");
  strobe_alternate_a: assert property (
    k_rise |-> !kn_rise ##1 !k_rise)
    else $error("K strobes not alternating");
  write_beats_a: assert property (
    wr_take |-> ##1 kn_rise ##1 k_rise ##1 kn_rise ##1 k_rise ##1 kn_rise)
    else $error("write beats not on following rises");
  read_latency_a: assert property (
    rd_take |-> ##5 q_oe [*4])
    else $error("read beats late or short");
  oe_cause_a: assert property (
    $rose(q_oe) |-> $past(rd_take, 5))
    else $error("read bus driven without a read");
  mask_in_burst_a: assert property (
    (k_rise || kn_rise) && lane_mask_n != '1 |-> $past(wr_take, 2)
    || $past(wr_take, 3) || $past(wr_take, 4) || $past(wr_take, 5))
    else $error("lane enabled outside a write burst");
  stop_hold_a: assert property (
    !$past(rst) && !$past(k_rise) && !$past(kn_rise)
    |-> $stable(q_oe) && (!q_oe || $stable(q)))
    else $error("read pins moved without a strobe");
endmodule

`default_nettype wire

// File: verif/quad_rate_sram_port_tb_top.sv
// Purpose: Self-checking bench for the burst SRAM port, both ends joined
// Assumes: 18-bit word, two lanes; link clock stopped only when idle
// Notes: A model array mirrors every write for the read-back compares
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_regs.svh"

module quad_rate_sram_port_tb_top;
  localparam int DW = `SP_DATA_W;
  localparam int MW = `SP_MASK_W;
  localparam int AW = `SP_ADDR_W;
  localparam int BW = `SP_BURST_LEN * DW;
  localparam int LW = `SP_LANE_W;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_run = 1'b1;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic [AW-1:0] rd_addr = '0;
  logic [AW-1:0] wr_addr = '0;
  logic [BW-1:0] wr_data = '0;
  logic [4*MW-1:0] wr_mask_n = '1;
  logic [BW-1:0] rd_data;
  logic rd_ack;
  logic wr_ack;
  logic rd_valid;
  logic read_active;
  logic write_active;
  logic [DW-1:0] mem_m [0:(1<<AW)-1];
  int error_cnt = 0;
  int check_count = 0;

  ////////////////////////////////////////////////////////////////
  // Both ends face each other; checker watches the link
  sram_port_if #(.DATA_W(DW), .MASK_W(MW), .ADDR_W(AW)) link_if ();
  sram_port_controller #(.DATA_W(DW), .MASK_W(MW), .ADDR_W(AW))
    sram_port_controller_inst (.clk(clk), .rst(rst), .link(link_if),
    .clk_run(clk_run), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_mask_n(wr_mask_n), .wr_ack(wr_ack), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sram_port_device #(.DATA_W(DW), .MASK_W(MW), .ADDR_W(AW))
    sram_port_device_inst (.clk(clk), .rst(rst), .link(link_if),
    .read_active(read_active), .write_active(write_active));
  sram_port_props #(.DATA_W(DW), .MASK_W(MW)) sram_port_props_inst (
    .clk(clk), .rst(rst), .k_rise(link_if.k_rise),
    .kn_rise(link_if.kn_rise), .read_select_n(link_if.read_select_n),
    .write_select_n(link_if.write_select_n),
    .lane_mask_n(link_if.lane_mask_n), .q(link_if.q), .q_oe(link_if.q_oe));

  // 100 MHz clock
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp,
                       input string what);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  // Bounded wait: 0 read ack, 1 write ack, 2 read data valid
  task automatic wait_sig(input int sel);
    int c;
    c = 0;
    do
    begin
      @(posedge clk);
      #1;
      c++;
      if (c > 40)
      begin
        error_cnt++;
        $display("unexpected at %0t: wait timed out", $time);
        end_of_test();
      end
    end while ((sel == 0 ? rd_ack : sel == 1 ? wr_ack : rd_valid) !== 1'b1);
  endtask

  // Request held until acked, then dropped on the next edge
  task automatic do_write(input logic [AW-1:0] a, input logic [BW-1:0] dat,
                          input logic [4*MW-1:0] m);
    @(posedge clk);
    wr_addr <= a;
    wr_data <= dat;
    wr_mask_n <= m;
    wr_req <= 1'b1;
    wait_sig(1);
    @(posedge clk);
    wr_req <= 1'b0;
    for (int i = 0; i < 4; i++)
      for (int l = 0; l < MW; l++)
        if (!m[i*MW+l])
          mem_m[AW'(a+i)][l*LW+:LW] = dat[i*DW+l*LW+:LW];
  endtask

  function automatic logic [BW-1:0] expect_at(input logic [AW-1:0] a);
    for (int i = 0; i < 4; i++)
      expect_at[i*DW+:DW] = mem_m[AW'(a+i)];
  endfunction

  task automatic do_read(input logic [AW-1:0] a);
    @(posedge clk);
    rd_addr <= a;
    rd_req <= 1'b1;
    wait_sig(0);
    @(posedge clk);
    rd_req <= 1'b0;
    wait_sig(2);
    check(rd_data, expect_at(a), "read burst data");
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(BW'(link_if.q_oe), '0, "read bus driven after reset");
    check(BW'({rd_ack, wr_ack, rd_valid}), '0, "acks after reset");
    $display("test reset done");
  endtask

  // Full bursts, the second wrapping past the top address
  task automatic t_full();
    do_write(8'h10, {18'h3FFFF, 18'h2AAAA, 18'h15555, 18'h00123}, '0);
    do_read(8'h10);
    do_write(8'hFE, {18'h0BEEF, 18'h1CAFE, 18'h22222, 18'h31111}, '0);
    do_read(8'hFE);
    $display("test full bursts done");
  endtask

  // Beat masks: both, upper only, lower only, none
  task automatic t_masks();
    do_write(8'h10, {4{18'h1F0F0}}, {2'b11, 2'b10, 2'b01, 2'b00});
    do_read(8'h10);
    $display("test lane masks done");
  endtask

  // Tie from idle: read goes first, write on the next K rise
  task automatic t_tie();
    int rd_at;
    int wr_at;
    int rd_busy;
    int wr_busy;
    logic [BW-1:0] got;
    rd_at = -9;
    wr_at = -1;
    rd_busy = 0;
    wr_busy = 0;
    do_write(8'h40, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, '0);
    repeat (6) @(posedge clk);
    rd_addr <= 8'h40;
    wr_addr <= 8'h80;
    wr_data <= {4{18'h2D2D2}};
    wr_mask_n <= '0;
    rd_req <= 1'b1;
    wr_req <= 1'b1;
    for (int c = 0; c < 30; c++)
    begin
      @(posedge clk);
      if (rd_at >= 0)
        rd_req <= 1'b0;
      if (wr_at >= 0)
        wr_req <= 1'b0;
      #1;
      if (rd_ack === 1'b1)
        rd_at = c;
      if (wr_ack === 1'b1)
        wr_at = c;
      if (rd_valid === 1'b1)
        got = rd_data;
      if (read_active === 1'b1)
        rd_busy++;
      if (write_active === 1'b1)
        wr_busy++;
    end
    check(BW'(wr_at - rd_at), BW'(`SP_CLK_PER_K), "tie order");
    check(got, expect_at(8'h40), "tie read data");
    check(BW'(rd_busy), BW'(2 * `SP_CLK_PER_K), "read burst span");
    check(BW'(wr_busy), BW'(2 * `SP_CLK_PER_K), "write burst span");
    for (int i = 0; i < 4; i++)
      mem_m[8'h80+i] = 18'h2D2D2;
    do_read(8'h80);
    $display("test tie done");
  endtask

  // Reads held back to back: gapless every other K rise
  task automatic t_back();
    int n;
    int v;
    int at [2];
    n = 0;
    v = 0;
    @(posedge clk);
    rd_addr <= 8'h10;
    rd_req <= 1'b1;
    for (int c = 0; c < 30; c++)
    begin
      @(posedge clk);
      if (n == 1)
        rd_addr <= 8'hFE;
      if (n == 2)
        rd_req <= 1'b0;
      #1;
      if (rd_ack === 1'b1 && n < 2)
      begin
        at[n] = c;
        n++;
      end
      if (rd_valid === 1'b1 && v < 2)
      begin
        check(rd_data, expect_at(v == 0 ? 8'h10 : 8'hFE), "stream");
        v++;
      end
    end
    check(BW'(at[1] - at[0]), BW'(2 * `SP_CLK_PER_K), "read spacing");
    check(BW'(v), BW'(2), "read bursts returned");
    $display("test back to back done");
  endtask

  // Stopped link clock: no strobes, nothing issued, pins hold
  task automatic t_stop();
    int stray;
    logic [DW-1:0] held;
    stray = 0;
    @(posedge clk);
    clk_run <= 1'b0;
    @(posedge clk);
    rd_addr <= 8'h40;
    rd_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    held = link_if.q;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      if (link_if.k_rise !== 1'b0 || link_if.kn_rise !== 1'b0)
        stray++;
      if (rd_ack !== 1'b0)
        stray++;
    end
    check(BW'(stray), '0, "activity while stopped");
    check(BW'(link_if.q), BW'(held), "read bus moved while stopped");
    @(posedge clk);
    clk_run <= 1'b1;
    wait_sig(0);
    @(posedge clk);
    rd_req <= 1'b0;
    wait_sig(2);
    check(rd_data, expect_at(8'h40), "read after restart");
    $display("test clock stop done");
  endtask

  // Reset in mid-burst: bus must drop and the link must still work
  task automatic t_rerun();
    @(posedge clk);
    rd_addr <= 8'h10;
    rd_req <= 1'b1;
    wait_sig(0);
    @(posedge clk);
    rd_req <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(BW'({link_if.q_oe, read_active}), '0, "busy after reset");
    do_read(8'h10);
    $display("test reset in mid-run done");
  endtask

  ////////////////////////////////////////////////////////////////
  // Reset for twelve cycles, then each scenario in turn
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_full();
    t_masks();
    t_tie();
    t_back();
    t_stop();
    t_rerun();
    end_of_test();
  end
endmodule

`default_nettype wire
